// file: design/discard_weight_table.sv
// Purpose: 16-entry random discard weight store
// Assumes: written one entry per cycle from the register side
// Notes: contents are left unreset on purpose
`timescale 1ns/10ps
module discard_weight_table (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [drop_stats_pkg::IDX_W-1:0] wr_idx_in,
    input wire logic [drop_stats_pkg::PROB_W-1:0] wr_data_in,
    input wire logic [drop_stats_pkg::IDX_W-1:0] rd_idx_in,
    output logic [drop_stats_pkg::PROB_W-1:0] rd_data_out,
    input wire logic [drop_stats_pkg::IDX_W-1:0] look1_idx_in,
    output logic [drop_stats_pkg::PROB_W-1:0] look1_prob_out,
    input wire logic [drop_stats_pkg::IDX_W-1:0] look2_idx_in,
    output logic [drop_stats_pkg::PROB_W-1:0] look2_prob_out
);
    // ****************************************
    // storage
    // ****************************************
    // no reset: software must fill all entries before use
    logic [drop_stats_pkg::PROB_W-1:0] weight_mem [drop_stats_pkg::ENTRIES];

    // single write port from the command sequencer
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            weight_mem[wr_idx_in] <= wr_data_in;
        end
    end

    // combinational read ports, registered by the caller
    assign rd_data_out = weight_mem[rd_idx_in];
    assign look1_prob_out = weight_mem[look1_idx_in];
    assign look2_prob_out = weight_mem[look2_idx_in];
endmodule : discard_weight_table

// file: design/drop_stats_discard_table.sv
// Purpose: drop counters, table-ready flag and discard table access
// Assumes: Avalon-MM slave, byte addresses, 32-bit data
// Notes: packet inputs come from same-clock logic, so no synchronisers
`timescale 1ns/10ps
module drop_stats_discard_table #(
    parameter int INIT_LEN = drop_stats_pkg::INIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // avalon-mm slave
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // ingress packet decisions, index 0 is port 1
    input wire drop_stats_pkg::pkt_t [1:0] pkt_in,
    output logic [1:0] drop_out,
    output logic tables_ready_flag_out,
    output logic irq_out
);
    // ****************************************
    // address decode
    // ****************************************
    // byte address of a register index
    function automatic logic [15:0] byte_addr(input logic [15:0] idx);
        byte_addr = {idx[13:0], 2'b00};
    endfunction : byte_addr

    // map buffer usage to table index
    function automatic logic [3:0] usage_index(input logic [7:0] used);
        if (used[7]) begin
            usage_index = {2'b11, used[6:5]};
        end else if (used[6]) begin
            usage_index = {2'b10, used[5:4]};
        end else begin
            usage_index = {1'b0, used[5:3]};
        end
    endfunction : usage_index

    // merge byte lanes of a write into an old value
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            lane_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction : lane_merge

    wire hit_cnt1 = avs_address_in == byte_addr(drop_stats_pkg::IDX_PORT1_DROP);
    wire hit_cnt2 = avs_address_in == byte_addr(drop_stats_pkg::IDX_PORT2_DROP);
    wire hit_stat = avs_address_in == byte_addr(drop_stats_pkg::IDX_INIT_STATUS);
    wire hit_cmd = avs_address_in == byte_addr(drop_stats_pkg::IDX_TABLE_CMD);
    wire hit_wdat = avs_address_in == byte_addr(drop_stats_pkg::IDX_TABLE_WDATA);
    wire hit_rdat = avs_address_in == byte_addr(drop_stats_pkg::IDX_TABLE_RDATA);
    wire hit_ctrl = avs_address_in == byte_addr(drop_stats_pkg::IDX_DISCARD_CTRL);
    wire hit_ists = avs_address_in == byte_addr(drop_stats_pkg::IDX_IRQ_STATUS);
    wire hit_imsk = avs_address_in == byte_addr(drop_stats_pkg::IDX_IRQ_MASK);

    // ****************************************
    // state
    // ****************************************
    logic [31:0] cnt_ff [2]; // per-port drop counters
    logic [31:0] nxt_cnt [2];
    logic [4:0] cmd_ff; // direction and index of last command
    logic cmd_pend_ff; // table access waiting one cycle
    logic [9:0] wdata_ff; // probability to write
    logic [9:0] rdata_ff; // probability read back
    logic [1:0] ctrl_ff; // drop-on-red, drop-on-yellow
    logic [3:0] ists_ff; // sticky interrupt status
    logic [3:0] imsk_ff; // interrupt mask
    logic rd_ack_ff; // second cycle of a register read
    logic [31:0] rdout_ff; // registered read data
    logic [1:0] drop_ff; // registered drop decisions
    logic [15:0] lfsr_ff; // random source
    logic [15:0] init_cnt_ff; // init walk counter
    drop_stats_pkg::init_state_t init_st_ff;
    drop_stats_pkg::init_state_t nxt_init_st;

    // ****************************************
    // bus handshake
    // ****************************************
    // reads take two cycles; any access stalls while a table op is pending
    wire rd_go = avs_read_in && !cmd_pend_ff && !rd_ack_ff;
    wire wr_take = avs_write_in && !cmd_pend_ff;
    assign avs_waitrequest_out = cmd_pend_ff ||
        (avs_read_in && !rd_ack_ff);
    assign avs_readdata_out = rdout_ff;

    // register write strobes
    wire wr_cmd = wr_take && hit_cmd && avs_byteenable_in[0];
    wire wr_wdat = wr_take && hit_wdat;
    wire wr_ctrl = wr_take && hit_ctrl;
    wire wr_ists = wr_take && hit_ists;
    wire wr_imsk = wr_take && hit_imsk;
    wire clr_cnt1 = rd_go && hit_cnt1;
    wire clr_cnt2 = rd_go && hit_cnt2;
    wire [31:0] wd_wdat = lane_merge({22'h0, wdata_ff},
        avs_writedata_in, avs_byteenable_in);
    wire [31:0] wd_ctrl = lane_merge({30'h0, ctrl_ff},
        avs_writedata_in, avs_byteenable_in);
    wire [31:0] wd_imsk = lane_merge({28'h0, imsk_ff},
        avs_writedata_in, avs_byteenable_in);
    wire [31:0] wd_ists = lane_merge(32'h0,
        avs_writedata_in, avs_byteenable_in);

    // read mux, unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_cnt1) begin
            rd_mux = cnt_ff[0];
        end else if (hit_cnt2) begin
            rd_mux = cnt_ff[1];
        end else if (hit_stat) begin
            rd_mux = {31'h0, tables_ready_flag_out};
        end else if (hit_cmd) begin
            rd_mux = {27'h0, cmd_ff};
        end else if (hit_wdat) begin
            rd_mux = {22'h0, wdata_ff};
        end else if (hit_rdat) begin
            rd_mux = {22'h0, rdata_ff};
        end else if (hit_ctrl) begin
            rd_mux = {30'h0, ctrl_ff};
        end else if (hit_ists) begin
            rd_mux = {28'h0, ists_ff};
        end else if (hit_imsk) begin
            rd_mux = {28'h0, imsk_ff};
        end
    end

    // capture read data and step the read handshake
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_ack_ff <= 1'b0;
            rdout_ff <= 32'h00000000;
        end else begin
            rd_ack_ff <= rd_go;
            if (rd_go) begin
                rdout_ff <= rd_mux;
            end
        end
    end

    // ****************************************
    // table init sequencer
    // ****************************************
    // walks the lookup tables after every reset
    wire init_last = init_cnt_ff == 16'(INIT_LEN - 1);
    always_comb begin
        nxt_init_st = init_st_ff;
        unique case (init_st_ff)
            drop_stats_pkg::INIT_RUN: begin
                if (init_last) begin
                    nxt_init_st = drop_stats_pkg::INIT_DONE;
                end
            end
            drop_stats_pkg::INIT_DONE: begin
                nxt_init_st = drop_stats_pkg::INIT_DONE;
            end
        endcase
    end

    // reset restarts the walk and drops the ready flag
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            init_st_ff <= drop_stats_pkg::INIT_RUN;
            init_cnt_ff <= 16'h0000;
        end else begin
            init_st_ff <= nxt_init_st;
            if (init_st_ff == drop_stats_pkg::INIT_RUN) begin
                init_cnt_ff <= init_cnt_ff + 16'h0001;
            end
        end
    end
    assign tables_ready_flag_out = init_st_ff == drop_stats_pkg::INIT_DONE;
    wire ready_rise = init_st_ff == drop_stats_pkg::INIT_RUN && init_last;

    // ****************************************
    // control registers
    // ****************************************
    // write data and drop control
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wdata_ff <= drop_stats_pkg::WDATA_RST;
            ctrl_ff <= drop_stats_pkg::CTRL_RST;
            imsk_ff <= drop_stats_pkg::IRQ_RST;
        end else begin
            if (wr_wdat) begin
                wdata_ff <= wd_wdat[9:0];
            end
            if (wr_ctrl) begin
                ctrl_ff <= wd_ctrl[1:0];
            end
            if (wr_imsk) begin
                imsk_ff <= wd_imsk[3:0];
            end
        end
    end

    // ****************************************
    // table command
    // ****************************************
    // latch command, run access on the following cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cmd_ff <= drop_stats_pkg::CMD_RST;
            cmd_pend_ff <= 1'b0;
        end else begin
            cmd_pend_ff <= wr_cmd;
            if (wr_cmd) begin
                cmd_ff <= avs_writedata_in[4:0];
            end
        end
    end

    wire cmd_is_read = cmd_ff[drop_stats_pkg::CMD_DIR_BIT];
    wire tbl_wr = cmd_pend_ff && !cmd_is_read;
    wire tbl_rd = cmd_pend_ff && cmd_is_read;
    wire [9:0] tbl_rd_data;
    wire [9:0] look_prob [2];
    wire [3:0] look_idx [2];

    // store result of a read command
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= 10'h000;
        end else if (tbl_rd) begin
            rdata_ff <= tbl_rd_data;
        end
    end

    discard_weight_table u_table (
        .clk_in(clk_in),
        .wr_en_in(tbl_wr),
        .wr_idx_in(cmd_ff[3:0]),
        .wr_data_in(wdata_ff),
        .rd_idx_in(cmd_ff[3:0]),
        .rd_data_out(tbl_rd_data),
        .look1_idx_in(look_idx[0]),
        .look1_prob_out(look_prob[0]),
        .look2_idx_in(look_idx[1]),
        .look2_prob_out(look_prob[1])
    );

    // ****************************************
    // random source
    // ****************************************
    // galois lfsr, low ten bits compared against probability
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            lfsr_ff <= drop_stats_pkg::LFSR_SEED;
        end else if (lfsr_ff[0]) begin
            lfsr_ff <= (lfsr_ff >> 1) ^ drop_stats_pkg::LFSR_TAPS;
        end else begin
            lfsr_ff <= lfsr_ff >> 1;
        end
    end

    // ****************************************
    // per-port drop decision and counters
    // ****************************************
    wire [1:0] drop_now;
    logic [1:0] sat_hit;
    wire [1:0] clr_cnt = {clr_cnt2, clr_cnt1};
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            // pick this port's entry from its buffer usage
            assign look_idx[p] = usage_index(pkt_in[p].used);
            wire is_yel = pkt_in[p].color == drop_stats_pkg::COLOR_YELLOW;
            wire is_red = pkt_in[p].color == drop_stats_pkg::COLOR_RED;
            wire rnd_hit = lfsr_ff[9:0] < look_prob[p];
            wire yel_drop = is_yel && ctrl_ff[drop_stats_pkg::CTRL_YELLOW_BIT]
                && rnd_hit;
            wire red_drop = is_red && ctrl_ff[drop_stats_pkg::CTRL_RED_BIT];
            assign drop_now[p] = pkt_in[p].valid &&
                (pkt_in[p].no_space || red_drop || yel_drop);

            // clear on read, but a same-cycle drop still counts
            always_comb begin
                nxt_cnt[p] = clr_cnt[p] ? 32'h00000000 : cnt_ff[p];
                sat_hit[p] = 1'b0;
                if (drop_now[p] && nxt_cnt[p] != drop_stats_pkg::CNT_MAX) begin
                    nxt_cnt[p] = nxt_cnt[p] + 32'h00000001;
                    sat_hit[p] = nxt_cnt[p] == drop_stats_pkg::CNT_MAX;
                end // saturate at all ones
            end

            // counter and decision flops
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    cnt_ff[p] <= drop_stats_pkg::CNT_RST;
                    drop_ff[p] <= 1'b0;
                end else begin
                    cnt_ff[p] <= nxt_cnt[p];
                    drop_ff[p] <= drop_now[p];
                end
            end
        end
    endgenerate
    assign drop_out = drop_ff;

    // ****************************************
    // interrupts
    // ****************************************
    // events: ready, counter saturated, table access done
    wire [3:0] irq_evt = {cmd_pend_ff, sat_hit[1], sat_hit[0], ready_rise};
    wire [3:0] irq_clr = wr_ists ? wd_ists[3:0] : 4'h0;

    // write one to clear; a new event wins over the clear
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ists_ff <= drop_stats_pkg::IRQ_RST;
        end else begin
            ists_ff <= (ists_ff & ~irq_clr) | irq_evt;
        end
    end
    assign irq_out = |(ists_ff & imsk_ff);
endmodule : drop_stats_discard_table

// file: design/drop_stats_pkg.sv
// Purpose: constants and types for the drop statistics and discard table
// Assumes: one switch-fabric clock, synchronous active-high reset
// Notes on behaviour
// - count every discarded packet per port
// - port 1 counter 32 bits, clears on read
// - port 2 counter identical, clears on read
// - counters saturate at all ones
// - ready flag zero after reset, self-sets
// - table initialisation reruns on every reset
// - command write launches one table access
// - command bit 4: 1 read, 0 write
// - read result lands in read data register
// - sixteen entries indexed by bits 3:0
// - index ranges: 8, 16, 32 buffers each
// - usage-selected entry gives drop probability
// - entries are 10-bit, 1/1024 units, yellow only
// - random discard only when drop-on-yellow set
package drop_stats_pkg;
    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [15:0] IDX_PORT1_DROP = 16'h1C06;
    localparam logic [15:0] IDX_PORT2_DROP = 16'h1C07;
    localparam logic [15:0] IDX_INIT_STATUS = 16'h1C08;
    localparam logic [15:0] IDX_TABLE_CMD = 16'h1C09;
    localparam logic [15:0] IDX_TABLE_WDATA = 16'h1C0A;
    localparam logic [15:0] IDX_TABLE_RDATA = 16'h1C0B;
    localparam logic [15:0] IDX_DISCARD_CTRL = 16'h1C10;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h1C11;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h1C12;
    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int CMD_DIR_BIT = 4;
    localparam int IDX_W = 4;
    localparam int PROB_W = 10;
    localparam int ENTRIES = 16;
    localparam int CNT_W = 32;
    localparam int USE_W = 8;
    localparam int NPORT = 2;
    localparam int NIRQ = 4;
    localparam int CTRL_YELLOW_BIT = 1;
    localparam int CTRL_RED_BIT = 0;
    localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFFFFFF;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h00000000;
    localparam logic [4:0] CMD_RST = 5'h00;
    localparam logic [PROB_W-1:0] WDATA_RST = 10'h000;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [NIRQ-1:0] IRQ_RST = 4'h0;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    // interrupt status bit positions
    localparam int IRQ_READY = 0;
    localparam int IRQ_SAT1 = 1;
    localparam int IRQ_SAT2 = 2;
    localparam int IRQ_TBL_DONE = 3;
    // ****************************************
    // timing: lookup table initialisation length
    // ****************************************
    localparam int INIT_CYCLES = 512;
    localparam logic [1:0] COLOR_GREEN = 2'h0;
    localparam logic [1:0] COLOR_YELLOW = 2'h1;
    localparam logic [1:0] COLOR_RED = 2'h2;
    // one packet decision request from the ingress path
    typedef struct packed {
        logic valid;
        logic no_space;
        logic [1:0] color;
        logic [USE_W-1:0] used;
    } pkt_t;
    // init sequencer states
    typedef enum logic [0:0] {
        INIT_RUN,
        INIT_DONE
    } init_state_t;
endpackage : drop_stats_pkg

// file: sim/drop_stats_chk.sv
// Purpose: port-level checker for the drop statistics block
// Assumes: one clock, synchronous active-high reset
// Notes: bound into the design top, sees its ports only
`timescale 1ns/10ps
module drop_stats_chk #(
    parameter int INIT_LEN = 8
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire drop_stats_pkg::pkt_t [1:0] pkt_in,
    input wire logic [1:0] drop_out,
    input wire logic tables_ready_flag_out,
    input wire logic irq_out
);
    // ****************************************
    // helpers
    // ****************************************
    localparam logic [15:0] A_RDATA = drop_stats_pkg::IDX_TABLE_RDATA << 2;
    localparam logic [15:0] A_STAT = drop_stats_pkg::IDX_INIT_STATUS << 2;
    localparam logic [15:0] A_CMD = drop_stats_pkg::IDX_TABLE_CMD << 2;
    logic [15:0] since_rst_ff; // cycles since reset release, saturating
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // count cycles after reset so ready timing can be bounded
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            since_rst_ff <= 16'h0000;
        end else if (since_rst_ff != 16'hFFFF) begin
            since_rst_ff <= since_rst_ff + 16'h0001;
        end
    end
    // a read that completes at the given address
    sequence s_read_done(logic [15:0] a);
        avs_read_in && !avs_waitrequest_out && avs_address_in == a;
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    a_ready_not_early: assert property (
        since_rst_ff < 16'(INIT_LEN - 2) |-> !tables_ready_flag_out)
        else $error("ready flag set too early");
    a_ready_on_time: assert property (
        since_rst_ff > 16'(INIT_LEN + 2) |-> tables_ready_flag_out)
        else $error("ready flag missing after init");
    a_ready_stays_set: assert property (
        tables_ready_flag_out |=> tables_ready_flag_out)
        else $error("ready flag dropped without reset");
    a_nospace_drop_p1: assert property (
        pkt_in[0].valid && pkt_in[0].no_space |=> drop_out[0])
        else $error("port 1 packet without space kept");
    a_nospace_drop_p2: assert property (
        pkt_in[1].valid && pkt_in[1].no_space |=> drop_out[1])
        else $error("port 2 packet without space kept");
    a_drop_needs_pkt: assert property (
        !pkt_in[0].valid && !pkt_in[1].valid |=> drop_out == 2'b00)
        else $error("drop without packet");
    a_green_passes: assert property (
        pkt_in[0].valid && !pkt_in[0].no_space &&
        pkt_in[0].color == drop_stats_pkg::COLOR_GREEN |=> !drop_out[0])
        else $error("green packet dropped");
    a_write_answered: assert property (
        avs_write_in |-> ##[0:2] !avs_waitrequest_out)
        else $error("write not answered");
    a_read_answered: assert property (
        $rose(avs_read_in) |->
        avs_waitrequest_out ##[1:2] !avs_waitrequest_out)
        else $error("read not answered in time");
    a_rdata_reserved: assert property (
        s_read_done(A_RDATA) |-> avs_readdata_out[31:10] == 22'h000000)
        else $error("read data upper bits set");
    a_status_reserved: assert property (
        s_read_done(A_STAT) |-> avs_readdata_out[31:1] == 31'h00000000)
        else $error("status upper bits set");
    a_cmd_reserved: assert property (
        s_read_done(A_CMD) |-> avs_readdata_out[31:5] == 27'h0000000)
        else $error("command upper bits set");
endmodule : drop_stats_chk

bind drop_stats_discard_table drop_stats_chk #(.INIT_LEN(INIT_LEN)) chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pkt_in(pkt_in),
    .drop_out(drop_out), .tables_ready_flag_out(tables_ready_flag_out),
    .irq_out(irq_out));

// file: sim/tb.sv
// Purpose: self-checking bench for the drop statistics block
// Assumes: short init length, bus tasks start just after a rising edge
// Notes: counter saturation is out of reach in a short run
`timescale 1ns/10ps
module tb;
    localparam int INIT_LEN = 8; // shortened table init
    logic clk_in, sys_rst_in, avs_read_in, avs_write_in;
    logic [15:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rv;
    logic [3:0] avs_byteenable_in;
    logic avs_waitrequest_out, tables_ready_flag_out, irq_out;
    drop_stats_pkg::pkt_t [1:0] pkt_in;
    logic [1:0] drop_out;
    int fail_count, checked;
    drop_stats_discard_table #(.INIT_LEN(INIT_LEN)) dut (.*);
    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic complete_run;
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // compare and report
    task automatic cmp(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s %h vs %h", $time, what, got, exp);
            fail_count++;
        end
    endtask : cmp
    // one avalon transfer, held until waitrequest is low at an edge
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        avs_address_in <= idx << 2;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 20);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n >= 20) begin
            cmp(32'h0, 32'h1, "bus timeout");
            complete_run();
        end
        @(posedge clk_in);
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [31:0] e,
                      input string what);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0, x);
        cmp(x, e, what);
    endtask : rd
    // one packet on a port; reports whether it was dropped
    task automatic pkt(input int p, input logic ns, input logic [1:0] c,
                       input logic [7:0] u, output logic d);
        pkt_in[p] <= '{valid: 1'b1, no_space: ns, color: c, used: u};
        @(posedge clk_in);
        pkt_in[p] <= '0;
        @(negedge clk_in);
        d = drop_out[p];
        @(posedge clk_in);
    endtask : pkt
    // table index that covers a buffer usage level
    function automatic logic [3:0] range_idx(input logic [7:0] u);
        if (u < 8'h40) return {1'b0, u[5:3]};
        if (u < 8'h80) return {2'b10, u[5:4]};
        return {2'b11, u[6:5]};
    endfunction : range_idx
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        int n;
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(negedge clk_in);
        cmp({31'h0, tables_ready_flag_out}, 32'h0, "ready early");
        n = 0;
        while (tables_ready_flag_out !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        cmp(32'(n >= INIT_LEN - 2 && n <= INIT_LEN + 1), 32'h1, "init");
        @(posedge clk_in);
        rd(drop_stats_pkg::IDX_INIT_STATUS, 32'h1, "status");
        rd(drop_stats_pkg::IDX_TABLE_CMD, 32'h0, "cmd reset");
    endtask : t_reset
    // ready event, mask, clear, unmapped place
    task automatic t_irq;
        rd(drop_stats_pkg::IDX_IRQ_STATUS, 32'h1, "irq status");
        cmp({31'h0, irq_out}, 32'h0, "irq masked");
        wr(drop_stats_pkg::IDX_IRQ_MASK, 32'h1);
        cmp({31'h0, irq_out}, 32'h1, "irq unmasked");
        wr(drop_stats_pkg::IDX_IRQ_STATUS, 32'h1);
        cmp({31'h0, irq_out}, 32'h0, "irq cleared");
        wr(16'h1C20, 32'hFFFFFFFF);
        rd(16'h1C20, 32'h0, "unmapped");
    endtask : t_irq
    // drop causes counted per port, cleared by the read
    task automatic t_counters;
        logic d;
        for (int p = 0; p < 2; p++) begin
            wr(drop_stats_pkg::IDX_DISCARD_CTRL, 32'h0);
            repeat (3) pkt(p, 1'b1, drop_stats_pkg::COLOR_GREEN, 8'h10, d);
            pkt(p, 1'b0, drop_stats_pkg::COLOR_RED, 8'h10, d);
            cmp({31'h0, d}, 32'h0, "red kept");
            wr(drop_stats_pkg::IDX_DISCARD_CTRL, 32'h1);
            pkt(p, 1'b0, drop_stats_pkg::COLOR_RED, 8'h10, d);
            cmp({31'h0, d}, 32'h1, "red dropped");
            rd(16'(drop_stats_pkg::IDX_PORT1_DROP + p), 32'h4, "count");
            rd(16'(drop_stats_pkg::IDX_PORT1_DROP + p), 32'h0, "clear");
        end
    endtask : t_counters
    // fill every entry, then read each back
    task automatic t_table;
        for (int i = 0; i < 16; i++) begin
            wr(drop_stats_pkg::IDX_TABLE_WDATA, 32'(i * 65 + 3));
            wr(drop_stats_pkg::IDX_TABLE_CMD, 32'(i));
        end
        for (int i = 0; i < 16; i++) begin
            wr(drop_stats_pkg::IDX_TABLE_CMD, 32'h10 | 32'(i));
            rd(drop_stats_pkg::IDX_TABLE_RDATA, 32'(i * 65 + 3), "entry");
        end
    endtask : t_table
    // odd entries drop at least 3 of 4 packets, even never; range edges probed
    task automatic t_random;
        logic d;
        int lv [13] = '{7, 8, 63, 64, 79, 80, 127, 128, 159, 160, 223,
            224, 255};
        int n, tot [2];
        tot = '{0, 0};
        for (int i = 0; i < 16; i++) begin
            wr(drop_stats_pkg::IDX_TABLE_WDATA, i[0] ? 32'h3FF : 32'h0);
            wr(drop_stats_pkg::IDX_TABLE_CMD, 32'(i));
        end
        wr(drop_stats_pkg::IDX_DISCARD_CTRL, 32'h2);
        foreach (lv[k]) begin
            n = 0;
            repeat (4) begin
                pkt(k % 2, 1'b0, drop_stats_pkg::COLOR_YELLOW, 8'(lv[k]), d);
                n += int'(d === 1'b1);
            end
            tot[k % 2] += n;
            cmp(32'(range_idx(8'(lv[k])) % 2 ? n >= 3 : n == 0), 32'h1,
                "range");
        end
        wr(drop_stats_pkg::IDX_DISCARD_CTRL, 32'h0);
        repeat (4) pkt(0, 1'b0, drop_stats_pkg::COLOR_YELLOW, 8'd8, d);
        cmp({31'h0, d}, 32'h0, "yellow off");
        rd(drop_stats_pkg::IDX_PORT1_DROP, 32'(tot[0]), "yellow count");
        rd(drop_stats_pkg::IDX_PORT2_DROP, 32'(tot[1]), "yellow count");
    endtask : t_random
    // main sequence, ending with a second reset
    initial begin
        fail_count = 0;
        checked = 0;
        sys_rst_in = 1'b1;
        avs_address_in = 16'h0000;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h00000000;
        avs_byteenable_in = 4'hF;
        pkt_in = '0;
        t_reset();
        t_irq();
        t_counters();
        t_table();
        t_random();
        t_reset();
        complete_run();
    end
endmodule : tb
